// ---- common/ebpw_pkg.sv ----
package ebpw_pkg;

	// ==========================================================
	// Zones and field layout of a zone timing word
	localparam int          NZONE       = 4;
	localparam int          ZW          = 2;
	localparam int          CW          = 5;
	localparam int          WSW         = 8;

	typedef struct packed {
		logic       ready_sample_async;
		logic       ready_use_en;
		logic       phase_double_sel;
		logic [1:0] wr_trail_cnt;
		logic [2:0] wr_active_cnt;
		logic [1:0] wr_lead_cnt;
		logic [1:0] rd_trail_cnt;
		logic [2:0] rd_active_cnt;
		logic [1:0] rd_lead_cnt;
	} ebpw_timing_t;

	localparam int          TIM_W       = $bits(ebpw_timing_t);
	localparam logic [16:0] TIMING_RST  = 17'h1FFFF;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0]  ZONE_BASE   = 8'h00;
	localparam logic [7:0]  CMD_OFF     = 8'h10;
	localparam logic [7:0]  STAT_OFF    = 8'h14;

	// Command word fields
	localparam int          CMD_WR_BIT  = 0;
	localparam int          CMD_ZONE_LO = 1;

	// Status word fields
	localparam int          STAT_BUSY   = 4;
	localparam int          STAT_WS_LO  = 8;

	// ==========================================================
	// Access phases, one-hot
	typedef enum logic [3:0] {
		PH_IDLE   = 4'b0001,
		PH_LEAD   = 4'b0010,
		PH_ACTIVE = 4'b0100,
		PH_TRAIL  = 4'b1000
	} ebpw_phase_t;

	// External strobes, all active low
	typedef struct packed {
		logic [NZONE-1:0] cs_n;
		logic             rd_n;
		logic             we_n;
	} ebpw_strobe_t;

	localparam logic [5:0]  STROBE_IDLE = 6'h3F;

endpackage

// ---- logic/ebpw_ext_bus_if.sv ----
module ebpw_ext_bus_if
	import ebpw_pkg::*;
(
	// Clock and reset
	input  wire  logic                  clk,
	input  wire  logic                  rst_n,
	// AHB-Lite slave
	input  wire  logic                  hsel,
	input  wire  logic [31:0]           haddr,
	input  wire  logic [1:0]            htrans,
	input  wire  logic                  hwrite,
	input  wire  logic [2:0]            hsize,
	input  wire  logic [31:0]           hwdata,
	input  wire  logic                  hready,
	output logic       [31:0]           hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	// External memory side
	input  wire  logic                  ext_ready_in,
	output ebpw_pkg::ebpw_strobe_t      strobe
);
	import ebpw_pkg::*;

	// ==========================================================
	// Bus slave
	logic               wsel_q;
	logic [7:0]         waddr_q;
	logic [31:0]        rdata_q;
	ebpw_timing_t       tim_q [NZONE];
	ebpw_phase_t        ph_q;
	ebpw_phase_t        ph_d;
	logic [CW-1:0]      cnt_q;
	logic [CW-1:0]      cnt_d;
	logic [WSW-1:0]     ws_q;
	logic [ZW-1:0]      zone_q;
	logic               wr_q;
	ebpw_strobe_t       strobe_q;
	logic               rdy_s1_q;
	logic               rdy_s2_q;
	logic               rdy_s3_q;

	// Address phase decode; only whole-word transfers are used
	wire         addr_go   = hsel & hready & htrans[1];
	wire  [7:0]  aoff      = haddr[7:0];
	wire         a_zone    = (aoff[7:4] == ZONE_BASE[7:4]);
	wire  [ZW-1:0] a_zidx  = aoff[ZW+1:2];
	wire  [ZW-1:0] w_zidx  = waddr_q[ZW+1:2];
	wire         w_zone    = wsel_q & (waddr_q[7:4] == ZONE_BASE[7:4]);
	wire         w_cmd     = wsel_q & (waddr_q == CMD_OFF);
	wire         st_idle   = (ph_q == PH_IDLE);
	wire         st_lead   = (ph_q == PH_LEAD);
	wire         st_act    = (ph_q == PH_ACTIVE);
	wire         st_trail  = (ph_q == PH_TRAIL);
	// A start while busy is dropped
	wire         start_go  = w_cmd & st_idle;

	// Status word shows the engine's own state
	wire  [31:0] stat_w    = {16'h0000, ws_q, 3'h0, ~st_idle, ph_q};
	wire  [31:0] rd_mux    = a_zone ? {15'h0000, tim_q[a_zidx]} :
	                         (aoff == STAT_OFF) ? stat_w : 32'h00000000;

	assign hrdata    = rdata_q;
	assign hreadyout = 1'b1;   // Zero wait states, always OKAY
	assign hresp     = 1'b0;

	// Latch write address phase, prepare read data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wsel_q  <= 1'b0;
			waddr_q <= 8'h00;
			rdata_q <= 32'h00000000;
		end else begin
			wsel_q  <= addr_go & hwrite;
			waddr_q <= aoff;
			rdata_q <= (addr_go & ~hwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NZONE; i++) tim_q[i] <= TIMING_RST;
		end else if (w_zone) begin
			tim_q[w_zidx] <= hwdata[TIM_W-1:0];
		end
	end

	// ==========================================================
	// Ready synchroniser; async mode takes one extra stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdy_s1_q <= 1'b0;
			rdy_s2_q <= 1'b0;
			rdy_s3_q <= 1'b0;
		end else begin
			rdy_s1_q <= ext_ready_in;
			rdy_s2_q <= rdy_s1_q;
			rdy_s3_q <= rdy_s2_q;
		end
	end

	// ==========================================================
	// Phase lengths of the selected zone
	// Zone comes from the command while idle, else the latched one
	wire  [ZW-1:0] zsel    = st_idle ? hwdata[CMD_ZONE_LO +: ZW] : zone_q;
	wire           wsel    = st_idle ? hwdata[CMD_WR_BIT] : wr_q;
	ebpw_timing_t  tz;
	assign tz = tim_q[zsel];
	wire           dbl     = tz.phase_double_sel;
	wire  [2:0]    lead_f  = wsel ? {1'b0, tz.wr_lead_cnt} :
	                                {1'b0, tz.rd_lead_cnt};
	wire  [2:0]    act_f   = wsel ? tz.wr_active_cnt : tz.rd_active_cnt;
	wire  [2:0]    trl_f   = wsel ? {1'b0, tz.wr_trail_cnt} :
	                                {1'b0, tz.rd_trail_cnt};
	wire  [CW-1:0] lead_len = dbl ? {1'b0, lead_f, 1'b0} : {2'b00, lead_f};
	// active is scaled field plus one; waits add on top
	wire  [CW-1:0] act_len  = (dbl ? {1'b0, act_f, 1'b0} : {2'b00, act_f})
	                          + 5'd1;
	wire  [CW-1:0] trl_len  = dbl ? {1'b0, trl_f, 1'b0} : {2'b00, trl_f};
	// ready looked at only when the zone enables it
	wire           rdy_now  = tz.ready_sample_async ? rdy_s3_q : rdy_s2_q;
	wire           hold_wait = tz.ready_use_en & ~rdy_now;
	wire           act_done = st_act & (cnt_q == 5'd0) & ~hold_wait;

	// lead, then active, then trail; zero-length phases skipped.
	// lengths are not checked, software owns the minimums
	always_comb begin
		ph_d  = ph_q;
		cnt_d = cnt_q;
		unique case (ph_q)
			PH_IDLE: begin
				if (start_go) begin
					ph_d  = (lead_len != 5'd0) ? PH_LEAD : PH_ACTIVE;
					cnt_d = (lead_len != 5'd0) ? lead_len - 5'd1 :
					                             act_len - 5'd1;
				end
			end
			PH_LEAD: begin
				if (cnt_q == 5'd0) begin
					ph_d  = PH_ACTIVE;
					cnt_d = act_len - 5'd1;
				end else begin
					cnt_d = cnt_q - 5'd1;
				end
			end
			PH_ACTIVE: begin
				if (cnt_q != 5'd0) begin
					cnt_d = cnt_q - 5'd1;
				end else if (!hold_wait) begin
					ph_d  = (trl_len != 5'd0) ? PH_TRAIL : PH_IDLE;
					cnt_d = (trl_len != 5'd0) ? trl_len - 5'd1 : 5'd0;
				end
			end
			PH_TRAIL: begin
				if (cnt_q == 5'd0) begin
					ph_d = PH_IDLE;
				end else begin
					cnt_d = cnt_q - 5'd1;
				end
			end
			default: begin
				ph_d  = PH_IDLE;
				cnt_d = 5'd0;
			end
		endcase
	end

	// each held cycle at the end of active is one wait state
	wire  [WSW-1:0] ws_d = start_go ? 8'h00 :
	                       (st_act & (cnt_q == 5'd0) & hold_wait) ?
	                       ws_q + 8'h01 : ws_q;

	// strobes come from flops on the timing clock edge
	ebpw_strobe_t  strobe_d;
	wire  [ZW-1:0] zone_d = start_go ? zsel : zone_q;
	wire           wr_d   = start_go ? wsel : wr_q;
	always_comb begin
		strobe_d = STROBE_IDLE;
		if (ph_d != PH_IDLE) strobe_d.cs_n[zone_d] = 1'b0;
		strobe_d.rd_n = ~((ph_d == PH_ACTIVE) & ~wr_d);
		strobe_d.we_n = ~((ph_d == PH_ACTIVE) & wr_d);
	end

	// Engine state; the timing clock is clk itself
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q     <= PH_IDLE;
			cnt_q    <= 5'd0;
			ws_q     <= 8'h00;
			zone_q   <= '0;
			wr_q     <= 1'b0;
			strobe_q <= STROBE_IDLE;
		end else begin
			ph_q     <= ph_d;
			cnt_q    <= cnt_d;
			ws_q     <= ws_d;
			zone_q   <= zone_d;
			wr_q     <= wr_d;
			strobe_q <= strobe_d;
		end
	end

	assign strobe = strobe_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_lead_to_active: assert property (
		st_lead |=> (st_lead || st_act)) else $error("lead left badly");
	a_trail_to_idle: assert property (
		st_trail |=> (st_trail || st_idle)) else $error("trail left badly");
	a_lead_load: assert property (
		(start_go && lead_len != 5'd0) |=>
		(st_lead && cnt_q == $past(lead_len) - 5'd1))
		else $error("lead length wrong");
	a_active_load: assert property (
		(st_lead && cnt_q == 5'd0) |=>
		(st_act && cnt_q == $past(act_len) - 5'd1))
		else $error("active length wrong");
	a_trail_load: assert property (
		(act_done && trl_len != 5'd0) |=>
		(st_trail && cnt_q == $past(trl_len) - 5'd1))
		else $error("trail length wrong");
	a_write_strobe: assert property (
		(st_act && wr_q) |-> (!strobe.we_n && strobe.rd_n))
		else $error("write strobe wrong");
	a_no_wait_ign: assert property (
		(st_act && !tz.ready_use_en) |-> ws_q == 8'h00)
		else $error("wait while ready ignored");
	a_wait_stretch: assert property (
		(st_act && cnt_q == 5'd0 && hold_wait) |=>
		(st_act && ws_q == $past(ws_q) + 8'h01))
		else $error("wait state not added");
	a_zone_select: assert property (
		st_lead |=> !strobe.cs_n[$past(zone_q)])
		else $error("zone select missing");
	a_read_strobe: assert property (
		(st_act && !wr_q) |-> (!strobe.rd_n && strobe.we_n))
		else $error("read strobe missing");

endmodule

// ---- verif/ebpw_ext_mem.sv ----
// ==========================================
// External device answering with ready
module ebpw_ext_mem
	import ebpw_pkg::*;
(
	// Clock, reset, stretch length
	input  wire  logic                   clk,
	input  wire  logic                   rst_n,
	input  wire  logic [7:0]             stall,
	// Strobes in, ready out
	input  wire  ebpw_pkg::ebpw_strobe_t strobe,
	output logic                         ext_ready_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       tog_q;
	wire        sel;
	// Any zone select low means an access runs
	assign sel = ~&strobe.cs_n;
	assign cnt_d = sel ? cnt_q + 8'h01 : 8'h00;
	// ready held low for the first stall cycles of a select
	// Unselected line toggles so no stale level is trusted
	assign ext_ready_in = sel ? (cnt_q >= stall) : tog_q;
	// Cycle count since select, free toggle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			tog_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tog_q <= ~tog_q;
		end
	end
endmodule

// ---- verif/ebpw_ext_bus_phase_wait_timing_bench.sv ----
// ==========================================
// Bench for the zoned phase timing core
module ebpw_ext_bus_phase_wait_timing_bench
	import ebpw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk;
	logic        rst_n;
	logic        hsel;
	logic        hwrite;
	logic        hreadyout;
	logic        hresp;
	logic        xrdy;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  stall;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	ebpw_strobe_t strobe;
	int          fail_count = 0;
	int          n_tests = 0;
	// Timing words: zone0 plain, zone1 doubled, zone2 sync, zone3 async
	// minimums kept by software
	logic [31:0] tw [4] = '{32'h85, 32'h517F, 32'h82A9, 32'h1C285};

	ebpw_ext_bus_if u_ebpw_ext_bus_if (.clk(clk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.ext_ready_in(xrdy), .strobe(strobe));
	ebpw_ext_mem u_ebpw_ext_mem (.clk(clk), .rst_n(rst_n),
		.stall(stall), .strobe(strobe), .ext_ready_in(xrdy));

	// Free running clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One single AHB-Lite transfer; read data lands in rd
	task automatic xfer(input logic w, input logic [31:0] a, d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(32'(hresp), 32'h0);
		hsel <= 1'b0;
	endtask

	// Start an access, measure its phases, compare with status
	task automatic acc(input logic [1:0] z, input logic w,
		input int el, ea, et, ew);
		int l;
		int a;
		int t;
		bit seen;
		l = 0;
		a = 0;
		t = 0;
		seen = 0;
		xfer(1'b1, 32'(CMD_OFF), {29'h0, z, w});
		repeat (300) begin
			@(negedge clk);
			if (strobe.cs_n[z] === 1'b0) seen = 1;
			else if (seen) break;
			else continue;
			if ((w ? strobe.we_n : strobe.rd_n) === 1'b0) a++;
			else if (a == 0) l++;
			else t++;
			chk(32'({strobe.cs_n | (4'h1 << z),
				w ? strobe.rd_n : strobe.we_n}), 32'h1F);
		end
		xfer(1'b0, 32'(STAT_OFF), 32'h0);
		chk(32'(rd[4:0]), 32'h01);
		chk(32'(rd[15:8]), 32'(ew));
		chk(32'(l), 32'(el));
		chk(32'(a), 32'(ea) + 32'(ew));
		chk(32'(t), 32'(et));
	endtask

	// Watchdog, far beyond the expected few hundred cycles
	initial begin
		#400000;
		fail_count++;
		close_out;
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		stall = 8'd12;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		chk(32'(strobe), 32'(STROBE_IDLE));
		xfer(1'b0, 32'(ZONE_BASE), 32'h0);
		chk(rd, 32'(TIMING_RST));
		xfer(1'b0, 32'h20, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < NZONE; i++) xfer(1'b1, 32'(i * 4), tw[i]);
		xfer(1'b0, 32'h04, 32'h0);
		chk(rd, tw[1]);
		acc(2'd0, 1'b0, 1, 2, 0, 0);
		acc(2'd0, 1'b1, 1, 1, 0, 0);
		acc(2'd1, 1'b0, 6, 15, 6, 0);
		acc(2'd1, 1'b1, 4, 1, 2, 0);
		// Ready low 12 cycles from select: 11 waits in either mode,
		// sync sees the pin after 2 flops, async after 3 with longer lead
		acc(2'd2, 1'b0, 1, 3, 1, 11);
		acc(2'd3, 1'b0, 2, 3, 0, 11);
		acc(2'd3, 1'b1, 2, 3, 0, 11);
		stall <= 8'd0;
		acc(2'd2, 1'b1, 1, 2, 0, 0);
		// Reset in mid-run brings back idle strobes and all-ones words
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk(32'(strobe), 32'(STROBE_IDLE));
		xfer(1'b0, 32'h04, 32'h0);
		chk(rd, 32'(TIMING_RST));
		close_out;
	end
endmodule
